// ---- ztb_pkg.sv ----
// Package for the zero-turnaround burst SRAM command block
package ztb_pkg;

   // Cycle kinds that the command decoder produces
   typedef enum logic [2:0] {
      ZTB_DESEL = 3'b000, // Deselect or continue deselect
      ZTB_READ = 3'b001, // Read with drivers on
      ZTB_DUMMY = 3'b010, // Read with drivers off
      ZTB_WRITE = 3'b011, // Write of at least one lane
      ZTB_ABORT = 3'b100 // Write with no lane
   } ztb_kind_e;

   // Reset values of the state
   localparam logic [1:0] ZTB_CNT_RST = 2'h0;
   localparam logic ZTB_BURST_WR_RST = 1'b0;

   // Burst order encodings of the order select pin
   localparam logic ZTB_ORDER_LINEAR = 1'b0;

   // Command inputs sampled on the rising edge
   typedef struct packed {
      logic select_n;
      logic expansion_select_lo_n;
      logic expansion_select_hi;
      logic advance_or_load_n;
      logic read_write;
   } ztb_cmd_s;

endpackage : ztb_pkg

// ---- ztb_burst_step.sv ----
// Next burst offset in linear or interleaved order
`timescale 1ns/1ps
module ztb_burst_step (
   input wire logic [1:0] start_off,
   input wire logic [1:0] count,
   input wire logic interleave,
   output logic [1:0] offset
);
   import ztb_pkg::*;

   // Offset after count advances from the loaded start
   always_comb begin
      if (interleave) begin
         offset = start_off ^ count;
      end else begin
         offset = 2'(start_off + count);
      end
   end
endmodule : ztb_burst_step

// ---- ztb_cmd.sv ----
// Command decoder and burst control of a zero-turnaround burst SRAM
`timescale 1ns/1ps
module ztb_cmd #(
   parameter int ADDR_W = 18, // Address width of the array
   parameter int LANES = 4, // Byte lanes, 2 or 4
   parameter int LANE_W = 9 // Bits per lane
) (
   input wire logic clock,
   input wire logic rst_b,
   input wire ztb_pkg::ztb_cmd_s cmd,
   input wire logic clock_gate_n,
   input wire logic sleep_request,
   input wire logic output_drive_n,
   input wire logic burst_order,
   input wire logic [ADDR_W-1:0] address,
   input wire logic [LANES-1:0] lane_write_group_n,
   input wire logic [LANES*LANE_W-1:0] data_in,
   output logic [LANES*LANE_W-1:0] data_out,
   output logic data_oe,
   output logic [ADDR_W-1:0] array_addr,
   output logic [LANES-1:0] array_lane_we,
   output logic [LANES*LANE_W-1:0] array_wdata,
   input wire logic [LANES*LANE_W-1:0] array_rdata,
   output ztb_pkg::ztb_kind_e cycle_kind
);
   import ztb_pkg::*;

   // Whole module state in one record
   typedef struct packed {
      logic [ADDR_W-1:0] base; // Loaded external address
      logic [1:0] count; // Burst advance count
      logic burst_wr; // Burst was started as a write
      logic selected; // Last load selected the device
      ztb_kind_e kind; // Kind of the current cycle
      logic oe; // Data pins driven
      logic [LANES*LANE_W-1:0] dout; // Output data
      logic [LANES-1:0] we; // Lane write strobes to array
      logic [LANES*LANE_W-1:0] wdata; // Write data to array
   } ztb_state_s;

   ztb_state_s state_reg; // Registered state
   ztb_state_s state_next; // Next state
   logic [1:0] next_count; // Count for this edge
   logic [1:0] offset; // Burst offset for this edge
   logic sel_now; // All selects true in this cycle
   logic any_lane; // At least one strobe low
   logic [LANES-1:0] lanes_low; // Strobes active high
   logic taken; // Edge neither stalled nor asleep

   // Burst address order, shared by reads and writes
   // order feeds step
   ztb_burst_step u_step (
      .start_off(state_reg.base[1:0]),
      .count(next_count),
      .interleave(burst_order != ZTB_ORDER_LINEAR),
      .offset(offset)
   );

   // Decoded inputs
   always_comb begin
      // Edge acts on the pins only when not gated or asleep
      taken = !clock_gate_n && !sleep_request;
      sel_now = !cmd.select_n && !cmd.expansion_select_lo_n
         && cmd.expansion_select_hi;
      lanes_low = ~lane_write_group_n;
      any_lane = |lanes_low;
      next_count = cmd.advance_or_load_n ? 2'(state_reg.count + 2'h1)
         : ZTB_CNT_RST;
   end

   // Next-state logic
   always_comb begin
      state_next = state_reg;
      // Array strobes last one cycle only
      state_next.we = '0;
      if (sleep_request) begin
         state_next.oe = 1'b0;
      end else if (clock_gate_n) begin
         // stalled write stays off, no write
         state_next.we = '0;
      end else if (!cmd.advance_or_load_n) begin
         state_next.base = address;
         state_next.count = ZTB_CNT_RST;
         state_next.selected = sel_now;
         state_next.burst_wr = !cmd.read_write;
      end else begin
         state_next.count = next_count;
      end
      if (!sleep_request && !clock_gate_n) begin
         if (!state_next.selected) begin
            state_next.kind = ZTB_DESEL;
            state_next.oe = 1'b0;
         end else if (state_next.burst_wr) begin
            state_next.oe = 1'b0;
            state_next.kind = any_lane ? ZTB_WRITE : ZTB_ABORT;
            state_next.we = lanes_low;
            state_next.wdata = data_in;
         end else begin
            // read drives only with control low
            state_next.kind = output_drive_n ? ZTB_DUMMY : ZTB_READ;
            state_next.oe = !output_drive_n;
            state_next.dout = array_rdata;
         end
      end
      if (!rst_b) begin
         state_next.count = ZTB_CNT_RST;
         state_next.burst_wr = ZTB_BURST_WR_RST;
         state_next.selected = 1'b0;
         state_next.kind = ZTB_DESEL;
         state_next.oe = 1'b0;
         state_next.we = '0;
         state_next.base = '0;
         state_next.dout = '0;
         state_next.wdata = '0;
      end
   end

   // State register, synchronous reset folded above
   always_ff @(posedge clock) begin
      state_reg <= state_next;
   end

   // Array address from state_reg and the pins, never from read data, so read data cannot loop back
   always_comb begin
      array_addr = state_reg.base; // Stall or sleep puts out the loaded base address
      if (taken && !cmd.advance_or_load_n) begin
         array_addr = address;
      end else if (taken) begin
         array_addr = {state_reg.base[ADDR_W-1:2], offset};
      end
   end

   // Registered outputs, data_oe also gated by sleep_request
   assign data_out = state_reg.dout;
   assign data_oe = state_reg.oe && !sleep_request;
   assign array_lane_we = state_reg.we;
   assign array_wdata = state_reg.wdata;
   assign cycle_kind = state_reg.kind;

   write_drv_off_a: assert property (
      @(posedge clock) disable iff (!rst_b)
      (state_reg.kind == ZTB_WRITE) |-> !data_oe)
      else $error("data driven during write");
   stall_no_wr_a: assert property (
      @(posedge clock) disable iff (!rst_b)
      clock_gate_n && !sleep_request |=> array_lane_we == '0)
      else $error("write during stall");
   stall_keep_a: assert property (
      @(posedge clock) disable iff (!rst_b)
      clock_gate_n |=> $stable(state_reg.count))
      else $error("count moved in stall");
   stall_read_a: assert property (
      @(posedge clock) disable iff (!rst_b)
      data_oe && clock_gate_n && !sleep_request ##1 !sleep_request
      |-> data_oe)
      else $error("read stall dropped drive");
   sleep_off_a: assert property (
      @(posedge clock) disable iff (!rst_b)
      sleep_request |-> !data_oe ##1 !state_reg.oe)
      else $error("driving in sleep");
   lane_match_a: assert property (
      @(posedge clock) disable iff (!rst_b)
      taken && !cmd.advance_or_load_n && sel_now && !cmd.read_write
      |=> array_lane_we == $past(lanes_low))
      else $error("wrong lanes written");
   desel_off_a: assert property (
      @(posedge clock) disable iff (!rst_b)
      taken && !cmd.advance_or_load_n && !sel_now
      ##1 taken && cmd.advance_or_load_n
      |=> !data_oe && array_lane_we == '0)
      else $error("continue deselect active");
   count_step_a: assert property (
      @(posedge clock) disable iff (!rst_b)
      taken && cmd.advance_or_load_n
      |=> state_reg.count == 2'($past(state_reg.count) + 2'h1))
      else $error("counter did not advance");
   noop_quiet_a: assert property (
      @(posedge clock) disable iff (!rst_b)
      (cycle_kind == ZTB_DUMMY || cycle_kind == ZTB_ABORT)
      |-> !data_oe && array_lane_we == '0)
      else $error("no-op cycle active");
   desel_load_a: assert property (
      @(posedge clock) disable iff (!rst_b)
      taken && !cmd.advance_or_load_n && !sel_now
      |=> cycle_kind == ZTB_DESEL && !state_reg.oe)
      else $error("unselected load acted");
   read_drive_a: assert property (
      @(posedge clock) disable iff (!rst_b)
      taken && !cmd.advance_or_load_n && sel_now && cmd.read_write
      && !output_drive_n |=> state_reg.oe && cycle_kind == ZTB_READ)
      else $error("read did not drive");
   // read with control high is dummy
   read_dummy_a: assert property (
      @(posedge clock) disable iff (!rst_b)
      taken && !cmd.advance_or_load_n && sel_now && cmd.read_write
      && output_drive_n |=> !state_reg.oe && cycle_kind == ZTB_DUMMY)
      else $error("dummy read drove");
   write_kind_a: assert property (
      @(posedge clock) disable iff (!rst_b)
      taken && !cmd.advance_or_load_n && sel_now && !cmd.read_write
      && !(&lane_write_group_n) |=> cycle_kind == ZTB_WRITE)
      else $error("strobed write not a write");
   abort_kind_a: assert property (
      @(posedge clock) disable iff (!rst_b)
      taken && !cmd.advance_or_load_n && sel_now && !cmd.read_write
      && (&lane_write_group_n) |=> cycle_kind == ZTB_ABORT)
      else $error("unstrobed write not aborted");
   write_data_a: assert property (
      @(posedge clock) disable iff (!rst_b)
      taken && !cmd.advance_or_load_n && sel_now && !cmd.read_write
      |=> array_wdata == $past(data_in))
      else $error("wrong write data");
   load_addr_a: assert property (
      @(posedge clock) disable iff (!rst_b)
      taken && !cmd.advance_or_load_n |-> array_addr == address)
      else $error("load address not used");
   load_count_a: assert property (
      @(posedge clock) disable iff (!rst_b)
      taken && !cmd.advance_or_load_n
      |=> state_reg.count == ZTB_CNT_RST)
      else $error("counter not restarted");
   type_kept_a: assert property (
      @(posedge clock) disable iff (!rst_b)
      taken && cmd.advance_or_load_n
      |=> state_reg.burst_wr == $past(state_reg.burst_wr))
      else $error("burst type changed");
   type_load_a: assert property (
      @(posedge clock) disable iff (!rst_b)
      taken && !cmd.advance_or_load_n
      |=> state_reg.burst_wr == !$past(cmd.read_write))
      else $error("burst type not loaded");
   burst_page_a: assert property (
      @(posedge clock) disable iff (!rst_b)
      taken && cmd.advance_or_load_n
      |-> array_addr[ADDR_W-1:2] == state_reg.base[ADDR_W-1:2])
      else $error("burst left its page");
   linear_order_a: assert property (
      @(posedge clock) disable iff (!rst_b)
      taken && cmd.advance_or_load_n && burst_order == ZTB_ORDER_LINEAR
      |-> array_addr[1:0]
      == 2'(state_reg.base[1:0] + state_reg.count + 2'h1))
      else $error("linear burst offset wrong");
   burst_xor_a: assert property (
      @(posedge clock) disable iff (!rst_b)
      taken && cmd.advance_or_load_n && burst_order != ZTB_ORDER_LINEAR
      |-> array_addr[1:0]
      == (state_reg.base[1:0] ^ 2'(state_reg.count + 2'h1)))
      else $error("interleaved burst offset wrong");
   stall_hold_a: assert property (
      @(posedge clock) disable iff (!rst_b)
      clock_gate_n && !sleep_request |=> $stable(state_reg.base)
      && $stable(cycle_kind) && $stable(data_out))
      else $error("stall changed state");
   sleep_hold_a: assert property (
      @(posedge clock) disable iff (!rst_b)
      sleep_request |=> $stable(state_reg.base)
      && $stable(state_reg.count) && array_lane_we == '0)
      else $error("sleep changed state");
   stall_wr_off_a: assert property (
      @(posedge clock) disable iff (!rst_b)
      state_reg.burst_wr && state_reg.selected && clock_gate_n
      && !sleep_request |=> !state_reg.oe)
      else $error("stalled write drove");
   lane_kind_a: assert property (
      @(posedge clock) disable iff (!rst_b)
      array_lane_we != '0 |-> cycle_kind == ZTB_WRITE)
      else $error("lane pulse outside write");
endmodule : ztb_cmd

// ---- ztb_array_model.sv ----
// Behavioural byte-lane array behind the command block
`timescale 1ns/1ps
module ztb_array_model (
   input wire logic clock,
   input wire logic [17:0] array_addr,
   input wire logic [3:0] array_lane_we,
   input wire logic [35:0] array_wdata,
   output logic [35:0] array_rdata
);
   // Sixteen words only; upper address bits alias
   logic [35:0] mem [16];
   // Address of the edge that launched a write pulse
   logic [17:0] addr_q;
   initial foreach (mem[i]) mem[i] = 36'h0;
   // Read port follows the address at once
   assign array_rdata = mem[addr_q === 18'hX ? 4'h0 : array_addr[3:0]];
   // Lane pulses land at the end of their cycle
   always @(posedge clock) begin
      addr_q <= array_addr;
      for (int i = 0; i < 4; i++) begin
         if (array_lane_we[i]) begin
            mem[addr_q[3:0]][9*i+:9] <= array_wdata[9*i+:9];
         end
      end
   end
endmodule : ztb_array_model

// ---- ztb_cmd_tb.sv ----
// Self-checking bench for the burst SRAM command block
`timescale 1ns/1ps
module ztb_cmd_tb;
   import ztb_pkg::*;
   // Outputs expected after one taken edge
   typedef struct packed {
      ztb_kind_e kind;
      logic oe;
      logic [3:0] we;
      logic [35:0] data;
   } ztb_exp_s;
   logic clock = 1'b0;
   logic rst_b = 1'b0;
   ztb_cmd_s cmd = '0;
   logic clock_gate_n = 1'b0;
   logic sleep_request = 1'b0;
   logic output_drive_n = 1'b0;
   logic burst_order = 1'b0;
   logic [17:0] address = '0;
   logic [3:0] lane_write_group_n = 4'hF;
   logic [35:0] data_in = '0;
   logic [35:0] data_out, array_wdata, array_rdata;
   logic data_oe;
   logic [17:0] array_addr, base;
   logic [3:0] array_lane_we;
   ztb_kind_e cycle_kind;
   // Notes queue and a mirror of the array
   ztb_exp_s exp_q[$];
   ztb_exp_s last;
   logic [35:0] ref_mem [16];
   logic [1:0] cnt, mode;
   logic act = 1'b0;
   logic cmp_ok;
   int error_cnt = 0;
   int comparisons = 0;
   int seed = 37286;
   always #20 clock = ~clock;
   ztb_cmd i_ztb_cmd (.*);
   ztb_array_model i_ztb_array_model (.*);
   task automatic check(input logic ok, input string msg);
      comparisons++;
      if (ok !== 1'b1) begin
         error_cnt++;
         $display("ERROR %0t %s", $time, msg);
      end
   endtask : check
   // One command; ctl is advance, read_write, drive control
   task automatic op(logic [2:0] sel, logic [2:0] ctl, logic [3:0] ln,
         logic [3:0] lo);
      ztb_exp_s e;
      logic [17:0] a;
      @(negedge clock);
      a = {14'($random(seed)), lo};
      {clock_gate_n, sleep_request, address} = {2'h0, a};
      {cmd, output_drive_n, lane_write_group_n} = {sel, ctl, ln};
      data_in = 36'({$random(seed), $random(seed)});
      if (!ctl[2]) begin
         {base, cnt} = {a, 2'h0};
         mode = sel != 3'h1 ? 2'h0 : ctl[1] ? 2'h1 : 2'h2;
      end else if (mode != 2'h0) cnt++;
      a = {base[17:2], burst_order ? base[1:0] ^ cnt : base[1:0] + cnt};
      e = '{ZTB_DESEL, 1'h0, 4'h0, ref_mem[a[3:0]]};
      // Reads drive only with the control low
      if (mode == 2'h1) begin
         e.kind = ctl[0] ? ZTB_DUMMY : ZTB_READ;
         e.oe = !ctl[0];
      end
      // Writes strobe exactly the lanes held low
      if (mode == 2'h2) begin
         e.kind = &ln ? ZTB_ABORT : ZTB_WRITE;
         e.we = ~ln;
         for (int i = 0; i < 4; i++) begin
            if (!ln[i]) ref_mem[a[3:0]][9*i+:9] = data_in[9*i+:9];
         end
      end
      exp_q.push_back(e);
      act = 1'b1;
   endtask : op
   // Ignored edge (s=0) or sleep (s=1) with a write load on the pins
   task automatic stall(input logic s);
      logic ok;
      @(negedge clock);
      {clock_gate_n, sleep_request, cmd, lane_write_group_n} = {!s, s, 9'h040};
      @(posedge clock) #1;
      ok = data_oe === (last.oe & !s) && array_lane_we === 4'h0;
      ok = ok && cycle_kind === last.kind;
      ok = ok && (data_oe !== 1'b1 || data_out === last.data);
      check(ok, "stall");
   endtask : stall
   // Compare each taken edge with the oldest note
   always @(posedge clock) begin
      if (act && rst_b && !clock_gate_n && !sleep_request) begin
         #1 last = exp_q.pop_front();
         cmp_ok = cycle_kind === last.kind && data_oe === last.oe;
         cmp_ok = cmp_ok && array_lane_we === last.we;
         cmp_ok = cmp_ok && (!last.oe || data_out === last.data);
         check(cmp_ok, "cycle result");
      end
   end
   // Order pin changes only while held in reset
   task automatic run(input logic order);
      @(negedge clock);
      {rst_b, act, burst_order, cmd} = {2'h0, order, 5'h00};
      repeat (3) @(negedge clock);
      {rst_b, mode} = {1'b1, 2'h0};
      op(3'h1, 3'h0, 4'h0, 4'h5);
      op(3'h1, 3'h6, 4'($random(seed)), 4'h0);
      op(3'h1, 3'h6, 4'hF, 4'h0);
      stall(1'b0);
      op(3'h1, 3'h6, 4'h7, 4'h0);
      for (int i = 0; i < 4; i++) begin
         op(3'h1, 3'h0, ~(4'h1 << i), 4'h9);
      end
      for (int i = 0; i < 3; i++) begin
         op(3'h1 ^ (3'h1 << i), 3'h0, 4'h0, 4'h9);
      end
      op(3'h1, 3'h4, 4'h0, 4'h0);
      op(3'h1, 3'h2, 4'h0, 4'h9);
      op(3'h1, 3'h2, 4'h0, 4'h5);
      op(3'h1, 3'h4, 4'h0, 4'h0);
      stall(1'b0);
      op(3'h1, 3'h5, 4'h0, 4'h0);
      op(3'h1, 3'h4, 4'h0, 4'h0);
      stall(1'b1);
      op(3'h1, 3'h3, 4'h0, 4'h9);
      $display("burst order %0d done", order);
   endtask : run
   initial begin
      foreach (ref_mem[i]) ref_mem[i] = 36'h0;
      run(1'b0);
      run(1'b1);
      @(negedge clock) act = 1'b0;
      check(exp_q.size() == 0, "notes left unchecked");
      tally_and_finish;
   end
   // Bound on the whole run
   initial begin
      repeat (2000) @(posedge clock);
      error_cnt++;
      tally_and_finish;
   end
   task automatic tally_and_finish;
      $display("comparisons %0d errors %0d", comparisons, error_cnt);
      if (error_cnt == 0 && comparisons > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask : tally_and_finish
endmodule : ztb_cmd_tb
